// ===== src/aiq_pkg.sv
// shared constants for the analog input point quality block
package aiq_pkg;
    localparam int NUM_CH = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SAMPLE_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_QUALITY = 4'hC;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hD;
    localparam logic [ADDR_W-1:0] ADDR_SECONDARY = 4'hE;
    localparam logic [ADDR_W-1:0] ADDR_CAL_LIMIT = 4'hF;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
    // bit positions in the main status word
    localparam int ST_CONFIGURED = 0;
    localparam int ST_FORCED_ERR = 1;
    localparam int ST_WARMING = 4;
    localparam int ST_UNCAL = 7;
    localparam int ST_CAL_FAIL = 12;
    localparam int ST_MEM_ERR = 13;
    localparam int ST_POINT_FAULT = 15;
    // quality word layout: two flags per channel
    localparam int Q_LINK = 0;
    localparam int Q_RANGE = 1;
    localparam int Q_PER_CH = 2;
    // current input thresholds in microamps, scaled 1 lsb = 1 uA
    localparam logic [SAMPLE_W-1:0] CUR_LOW_UA = 16'h09C4;
    localparam logic [SAMPLE_W-1:0] CUR_HIGH_UA = 16'h6018;
    // voltage full scale in counts, signed; 121% limit derived below
    localparam int VOLT_FS = 16'h2000;
    localparam int VOLT_OVER_PCT = 121;
    localparam logic signed [SAMPLE_W-1:0] VOLT_LIMIT =
        SAMPLE_W'((VOLT_FS * VOLT_OVER_PCT) / 100);
    localparam logic [DATA_W-1:0] CAL_LIMIT_RESET = 16'h0100;
    // bus activity hold time for the comms lamp
    localparam int COMM_HOLD_US = 100;
    localparam int CLK_MHZ = 20;
    localparam int COMM_HOLD_CYC = COMM_HOLD_US * CLK_MHZ;
    localparam int COMM_W = 12;
    localparam logic [COMM_W-1:0] COMM_HOLD = COMM_W'(COMM_HOLD_CYC);
    localparam logic [COMM_W-1:0] COMM_ZERO = 12'h000;
endpackage

// ===== src/aiq_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module aiq_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stage1;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stage1 <= '0;
            syncOut <= '0;
        end else if (clkEn) begin
            stage1 <= pinIn;
            syncOut <= stage1;
        end
    end
endmodule

// ===== src/aiq_channel_check.sv
// per channel quality evaluation of a completed measurement
`timescale 1ns/10ps
module aiq_channel_check
    import aiq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic sampleValid,
    input wire logic [SAMPLE_W-1:0] sample,
    input wire logic isCurrent,
    input wire logic linkFail,
    input wire logic [DATA_W-1:0] calLimit,
    input wire logic [SAMPLE_W-1:0] calReading,
    input wire logic calValid,
    output logic linkFlag,
    output logic rangeFlag,
    output logic calBad
);
    logic signed [SAMPLE_W-1:0] sSample;
    logic signed [SAMPLE_W-1:0] sCal;
    logic curBad;
    logic voltBad;
    logic calOut;
    assign sSample = sample;
    assign sCal = calReading;
    assign curBad = (sample < CUR_LOW_UA) || (sample > CUR_HIGH_UA);
    assign voltBad = (sSample >= VOLT_LIMIT) || (sSample <= -VOLT_LIMIT);
    assign calOut = (sCal > $signed(calLimit)) || (sCal < -$signed(calLimit));
    // flags follow each new sample, cal reading or link level so they clear when the condition goes away
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            linkFlag <= 1'b0;
            rangeFlag <= 1'b0;
            calBad <= 1'b0;
        end else if (clkEn) begin
            linkFlag <= linkFail;
            if (sampleValid) begin
                rangeFlag <= isCurrent ? curBad : voltBad;
            end
            if (calValid) begin
                calBad <= calOut;
            end
        end
    end
endmodule

// ===== src/analog_input_point_quality.sv
// register bank and diagnostic lamps for an eight channel analog input
// Contract
// - secondary word address 14 reads zero
// - read-only quality word at address 12
// - two flags per channel, bits 0-15
// - link failure sets channel link flag
// - current below 2.5mA or above 24.6mA flags
// - voltage at 121% full scale flags range
// - power lamp lit while +5V good
// - comms lamp lit during controller traffic
// - internal error lamp for module errors
// - per channel error lamp for channel errors
// - voltage above +121% lights channel lamp
// - voltage below -121% lights channel lamp
// - self-calibration out of range lights lamp
// - point fault bit ORs quality and errors
// - quality word meaningful only for point faults
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module analog_input_point_quality
    import aiq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    input wire logic [NUM_CH-1:0] sampleValid,
    input wire logic [NUM_CH*SAMPLE_W-1:0] sampleData,
    input wire logic [NUM_CH-1:0] chanIsCurrent,
    input wire logic [NUM_CH-1:0] calValid,
    input wire logic [NUM_CH*SAMPLE_W-1:0] calData,
    input wire logic [NUM_CH-1:0] linkFailPin,
    input wire logic powerGoodPin,
    input wire logic fieldLinkFailPin,
    input wire logic initBusy,
    input wire logic busTimeout,
    input wire logic memError,
    input wire logic uncalibrated,
    input wire logic warming,
    input wire logic calFailed,
    output logic powerLamp,
    output logic commsLamp,
    output logic internalErrLamp,
    output logic [NUM_CH-1:0] per_channel_fault_lamps
);
    typedef enum logic [1:0] {
        AIQ_ST_RESET = 2'b00,
        AIQ_ST_INIT = 2'b01,
        AIQ_ST_RUN = 2'b10
    } aiq_state_t;

    aiq_state_t state;
    aiq_state_t next_state;
    logic [NUM_CH-1:0] linkSync;
    logic powerSync;
    logic fieldSync;
    logic [NUM_CH-1:0] linkFlag;
    logic [NUM_CH-1:0] rangeFlag;
    logic [NUM_CH-1:0] calBad;
    logic [DATA_W-1:0] qualityWord;
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] calLimit;
    logic configured;
    logic forceErr;
    logic moduleErr;
    logic anyPointBad;
    logic inReset;
    logic busActive;
    logic [COMM_W-1:0] commCount;
    logic [DATA_W-1:0] next_rdata;
    logic hitStatus;
    logic hitCal;

    // pin levels from the field side cross into this clock first
    aiq_sync #(.W(NUM_CH + 2)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .clkEn(clkEn),
        .pinIn({linkFailPin, powerGoodPin, fieldLinkFailPin}),
        .syncOut({linkSync, powerSync, fieldSync})
    );

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            aiq_channel_check u_chk (
                .clk_sys(clk_sys),
                .reset(reset),
                .clkEn(clkEn),
                .sampleValid(sampleValid[ch]),
                .sample(sampleData[ch*SAMPLE_W +: SAMPLE_W]),
                .isCurrent(chanIsCurrent[ch]),
                .linkFail(linkSync[ch]),
                .calLimit(calLimit),
                .calReading(calData[ch*SAMPLE_W +: SAMPLE_W]),
                .calValid(calValid[ch]),
                .linkFlag(linkFlag[ch]),
                .rangeFlag(rangeFlag[ch]),
                .calBad(calBad[ch])
            );
            assign qualityWord[ch*Q_PER_CH + Q_LINK] = linkFlag[ch];
            assign qualityWord[ch*Q_PER_CH + Q_RANGE] = rangeFlag[ch];
        end
    endgenerate

    // reset and init phases count as module errors for the lamp
    always_comb begin
        next_state = state;
        case (state)
            AIQ_ST_RESET: next_state = AIQ_ST_INIT;
            AIQ_ST_INIT: next_state = initBusy ? AIQ_ST_INIT : AIQ_ST_RUN;
            AIQ_ST_RUN: next_state = AIQ_ST_RUN;
            default: next_state = AIQ_ST_RESET;
        endcase
    end

    assign inReset = (state != AIQ_ST_RUN);
    assign moduleErr = forceErr | memError | uncalibrated | calFailed;
    assign anyPointBad = |qualityWord;

    always_comb begin
        statusWord = ZERO_WORD;
        statusWord[ST_CONFIGURED] = configured;
        statusWord[ST_FORCED_ERR] = forceErr | memError;
        statusWord[ST_WARMING] = warming;
        statusWord[ST_UNCAL] = uncalibrated;
        statusWord[ST_CAL_FAIL] = calFailed;
        statusWord[ST_MEM_ERR] = memError;
        statusWord[ST_POINT_FAULT] = anyPointBad | moduleErr;
    end

    assign hitStatus = (regAddr == ADDR_STATUS);
    assign hitCal = (regAddr == ADDR_CAL_LIMIT);

    // quality word is reported as is; software reads it only on point faults
    always_comb begin
        next_rdata = ZERO_WORD;
        case (regAddr)
            ADDR_QUALITY: next_rdata = qualityWord;
            ADDR_STATUS: next_rdata = statusWord;
            ADDR_SECONDARY: next_rdata = ZERO_WORD;
            ADDR_CAL_LIMIT: next_rdata = calLimit;
            default: next_rdata = ZERO_WORD;
        endcase
    end

    assign busActive = regRead | regWrite;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= AIQ_ST_RESET;
            regRdata <= ZERO_WORD;
            configured <= 1'b0;
            forceErr <= 1'b0;
            calLimit <= CAL_LIMIT_RESET;
        end else if (clkEn) begin
            state <= next_state;
            regRdata <= regRead ? next_rdata : ZERO_WORD;
            if (regWrite && hitStatus) begin
                configured <= regWdata[ST_CONFIGURED];
                forceErr <= regWdata[ST_FORCED_ERR];
            end
            if (regWrite && hitCal) begin
                calLimit <= regWdata;
            end
        end
    end

    // comms lamp holds a little after each access so it is visible
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            commCount <= COMM_ZERO;
        end else if (clkEn) begin
            if (busActive) begin
                commCount <= COMM_HOLD;
            end else if (commCount != COMM_ZERO) begin
                commCount <= commCount - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            powerLamp <= 1'b0;
            commsLamp <= 1'b0;
            internalErrLamp <= 1'b1;
            per_channel_fault_lamps <= '0;
        end else if (clkEn) begin
            powerLamp <= powerSync;
            commsLamp <= busActive | (commCount != COMM_ZERO);
            internalErrLamp <= inReset | initBusy | busTimeout | moduleErr | warming
                | fieldSync;
            per_channel_fault_lamps <= rangeFlag | calBad | linkFlag;
        end
    end
endmodule

// ===== verification/aiq_host_model.sv
// controller model issuing register reads and writes
`timescale 1ns/10ps
module aiq_host_model
    import aiq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [DATA_W-1:0] regRdata,
    output logic [ADDR_W-1:0] regAddr,
    output logic [DATA_W-1:0] regWdata,
    output logic regWrite,
    output logic regRead
);
    initial begin
        regAddr = 4'h0;
        regWdata = 16'h0000;
        regWrite = 1'h0;
        regRead = 1'h0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clk_sys);
        regWrite <= 1'h0;
        // released bus shows the inverse so stale data is never mistaken
        regWdata <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clk_sys);
        regRead <= 1'h0;
        // data stand for one cycle; taken at the edge that closes it
        @(posedge clk_sys);
        d = regRdata;
    endtask
endmodule

// ===== verification/aiq_chk.sv
// assertions on the point quality block ports
`timescale 1ns/10ps
module aiq_chk
    import aiq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic [NUM_CH-1:0] sampleValid,
    input wire logic [NUM_CH*SAMPLE_W-1:0] sampleData,
    input wire logic [NUM_CH-1:0] chanIsCurrent,
    input wire logic [NUM_CH-1:0] linkFailPin,
    input wire logic powerGoodPin,
    input wire logic busTimeout,
    input wire logic memError,
    input wire logic uncalibrated,
    input wire logic powerLamp,
    input wire logic commsLamp,
    input wire logic internalErrLamp,
    input wire logic [NUM_CH-1:0] per_channel_fault_lamps
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    wire [SAMPLE_W-1:0] s0 = sampleData[SAMPLE_W-1:0];
    wire v0 = sampleValid[0] && clkEn;
    a_rdata_idle: assert property (!$past(regRead) && $past(clkEn) |-> regRdata == ZERO_WORD)
        else $error("read data outside read slot");
    a_secondary_zero: assert property (regRead && clkEn && regAddr == ADDR_SECONDARY |=> regRdata == ZERO_WORD)
        else $error("secondary word not zero");
    a_power_on: assert property (powerGoodPin [*6] |-> powerLamp)
        else $error("power lamp dark");
    a_power_off: assert property (!powerGoodPin [*6] |-> !powerLamp)
        else $error("power lamp lit");
    a_comms_on: assert property ((regRead || regWrite) && clkEn |-> ##[1:3] commsLamp)
        else $error("comms lamp dark");
    a_int_err: assert property ((memError || busTimeout || uncalibrated) |-> ##[1:3] internalErrLamp)
        else $error("error lamp dark");
    a_link_lamp: assert property (linkFailPin[0] [*6] |-> per_channel_fault_lamps[0])
        else $error("link lamp dark");
    a_volt_over: assert property (v0 && !chanIsCurrent[0] && $signed(s0) >= VOLT_LIMIT |-> ##[1:3] per_channel_fault_lamps[0])
        else $error("overrange lamp dark");
    a_cur_bad: assert property (v0 && chanIsCurrent[0] && (s0 < CUR_LOW_UA || s0 > CUR_HIGH_UA) |-> ##[1:3] per_channel_fault_lamps[0])
        else $error("current lamp dark");
    c_cur_sample: cover property (v0 && chanIsCurrent[0]);
    c_quality_read: cover property (regRead && regAddr == ADDR_QUALITY);
    c_comms_idle: cover property ($fell(commsLamp));
endmodule
bind analog_input_point_quality aiq_chk i_aiq_chk (.clk_sys, .reset, .clkEn, .regAddr, .regWrite,
    .regRead, .regRdata, .sampleValid, .sampleData, .chanIsCurrent, .linkFailPin, .powerGoodPin,
    .busTimeout, .memError, .uncalibrated, .powerLamp, .commsLamp, .internalErrLamp,
    .per_channel_fault_lamps);

// ===== verification/test_analog_input_point_quality.sv
// self-checking bench for the point quality block
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module test_analog_input_point_quality;
    import aiq_pkg::*;
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, rv;
    logic regWrite, regRead, powerLamp, commsLamp, internalErrLamp;
    logic [NUM_CH-1:0] sampleValid = '0, chanIsCurrent = '0, calValid = '0, linkFailPin = '0, lamps;
    logic [NUM_CH*SAMPLE_W-1:0] sampleData = '0, calData = '0;
    logic powerGoodPin = 1'h1;
    logic [3:0] errVec = 4'h0;
    // table of boundary samples: current mask, bad mask, values
    logic [8:0] curM = 9'h1F0;
    logic [8:0] badM = 9'h095;
    logic [15:0] val[9] = '{16'h26B8, 16'h26B7, 16'hD948, 16'hD949, 16'h09C3, 16'h09C4,
        16'h6018, 16'h6019, 16'h2EE0};
    int err_total = 0;
    int samples_checked = 0;
    always #25 clk_sys = ~clk_sys;
    aiq_host_model host (.clk_sys, .regRdata, .regAddr, .regWdata, .regWrite, .regRead);
    analog_input_point_quality i_analog_input_point_quality (.clk_sys, .reset, .clkEn(1'h1),
        .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .sampleValid, .sampleData,
        .chanIsCurrent, .calValid, .calData, .linkFailPin, .powerGoodPin,
        .fieldLinkFailPin(errVec[3]), .initBusy(1'h0), .busTimeout(errVec[2]),
        .memError(errVec[1]), .uncalibrated(errVec[0]), .warming(1'h0), .calFailed(1'h0),
        .powerLamp, .commsLamp, .internalErrLamp, .per_channel_fault_lamps(lamps));
    task automatic wt(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic smp(int c, logic cur, logic [SAMPLE_W-1:0] v);
        @(posedge clk_sys);
        chanIsCurrent[c] <= cur;
        sampleData[c*SAMPLE_W +: SAMPLE_W] <= v;
        sampleValid[c] <= 1'h1;
        @(posedge clk_sys);
        sampleValid[c] <= 1'h0;
        sampleData[c*SAMPLE_W +: SAMPLE_W] <= ~v;
        wt(6);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        wt(20000);
        err_total++;
        test_done();
    end
    initial begin
        wt(5);
        `CHK(internalErrLamp, 1'h1)
        reset <= 1'h0;
        wt(8);
        host.rd(ADDR_SECONDARY, rv);
        `CHK(rv, ZERO_WORD)
        host.wr(ADDR_QUALITY, 16'hFFFF);
        host.rd(ADDR_QUALITY, rv);
        `CHK(rv, ZERO_WORD)
        `CHK({powerLamp, commsLamp, internalErrLamp}, 3'h6)
        for (int c = 0; c < NUM_CH; c++) begin
            linkFailPin[c] <= 1'h1;
            wt(6);
            host.rd(ADDR_QUALITY, rv);
            `CHK(rv, 16'h0001 << (2 * c))
            `CHK(lamps[c], 1'h1)
            host.rd(ADDR_STATUS, rv);
            `CHK(rv[ST_POINT_FAULT], 1'h1)
            linkFailPin[c] <= 1'h0;
            for (int k = 0; k < 9; k++) begin
                smp(c, curM[k], val[k]);
                host.rd(ADDR_QUALITY, rv);
                `CHK(rv, badM[k] ? 16'h0002 << (2 * c) : ZERO_WORD)
                `CHK(lamps[c], badM[k])
            end
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            calData[15:0] <= 16'h0101 - 16'(k);
            calValid[0] <= 1'h1;
            @(posedge clk_sys);
            calValid[0] <= 1'h0;
            wt(6);
            `CHK(lamps[0], k == 0)
        end
        host.wr(ADDR_STATUS, 16'h0003);
        host.rd(ADDR_STATUS, rv);
        `CHK({rv[ST_FORCED_ERR], rv[ST_POINT_FAULT]}, 2'h3)
        `CHK(internalErrLamp, 1'h1)
        host.wr(ADDR_STATUS, 16'h0001);
        powerGoodPin <= 1'h0;
        wt(6);
        `CHK(powerLamp, 1'h0)
        powerGoodPin <= 1'h1;
        wt(2100);
        `CHK(commsLamp, 1'h0)
        for (int i = 0; i < 4; i++) begin
            errVec <= 4'h1 << i;
            wt(6);
            host.rd(ADDR_STATUS, rv);
            `CHK(rv[ST_POINT_FAULT], i < 2)
            `CHK(internalErrLamp, 1'h1)
        end
        test_done();
    end
endmodule
